//--- core/dic_ctrl.sv
`timescale 1ns/10ps
// How it works
// R1 - Fixed priority, reset highest, timer lowest, sleep at 002C, own vectors.
// R2 - Pending requests ANDed with mask; highest surviving one is chosen.
// R3 - All sources maskable except sleep and reset.
// R4 - One cycle after a mask write, no interrupt is taken.
// R5 - Control picks nesting and edge or level for three configurable lines.
// R6 - The two level lines are always level-sensitive.
// R7 - Edge line always edge-latched; software can set and clear it.
// R8 - Write-only force/clear port sets or clears single requests.
// R9 - Status pushed on a twelve-deep stack at entry, popped on return.
// R10 - Global on/off gates all servicing, sleep included.
// R11 - Global servicing is enabled after reset.
// R12 - Shared flag pins raise requests whoever drives them.
// R13 - Extra lines from serial port b use vectors 0020 and 0024.
// R14 - Idle waits for an unmasked interrupt, then resumes after idle.
// R15 - Cycle steals continue in idle.
// R16 - Slow idle divides clocks by 16, 32, 64 or 128; none means idle.
// R17 - In slow idle, wake takes at most divisor cycles.
// R18 - Sources must not interrupt faster than slow idle can exit.
// R19 - Sleep requested by pin or software; nonmaskable edge request.
// R20 - Sleep recovery 100 cycles with clock, about 4096 if stopped.
// R21 - Context select on sleep exit; reset also ends sleep.
// R22 - Sleep acknowledge asserted once sleep is really entered.
// R23 - Latched edge request stays until taken or cleared by software.
module dic_ctrl
  import dic_pkg::*;
#(
  parameter int STOP_REC = STOP_REC_CYC
) (
  input  wire logic            sys_clk,
  input  wire logic            rst,
  input  wire logic            cfg_sense_line_c,
  input  wire logic            level_line_a,
  input  wire logic            level_line_b,
  input  wire logic            edge_line,
  input  wire logic            cfg_sense_line_a,
  input  wire logic            cfg_sense_line_b,
  input  wire logic            lines_from_port_b,
  input  wire logic [3:0]      periph_req,
  input  wire logic            sleep_request_in,
  input  wire logic            sleep_force,
  input  wire logic            osc_stopped,
  input  wire logic            powerup_context_reset_sel,
  input  wire logic [NSRC-1:0] source_gate_wdata,
  input  wire logic            source_gate_we,
  input  wire logic [3:0]      ctrl_wdata,
  input  wire logic            ctrl_we,
  input  wire logic [NSRC-1:0] force_bits,
  input  wire logic [NSRC-1:0] clear_bits,
  input  wire logic            force_clear_we,
  input  wire logic            global_service_on,
  input  wire logic            global_service_off,
  input  wire logic            vector_accept,
  input  wire logic            handler_return,
  input  wire logic [15:0]     status_in,
  input  wire logic            idle_cmd,
  input  wire logic [2:0]      idle_div_sel,
  output logic [15:0]          status_out,
  output logic                 stack_overflow,
  output dic_vec_t             vec_out,
  output logic                 idle_active,
  output logic                 slow_tick,
  output logic                 sleep_ack_out,
  output logic                 context_clear,
  output logic                 core_resume,
  output logic [NSRC-1:0]      pending_out
);

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  logic [NSRC-1:0] mask_r, mask_nxt, pend_r, pend_nxt, active_r, active_nxt;
  logic [3:0]      ctrl_r, ctrl_nxt;
  logic            gen_r, gen_nxt, hold_r, hold_nxt;
  logic [NSRC-1:0] raw, raw_q_r, rise, latch_en;
  logic [NSRC-1:0] gated, gsel;
  dic_vec_t        sel, vec_r;
  logic [15:0]     stk_r [STK_DEPTH];
  logic [3:0]      sp_r, sp_nxt;
  logic [15:0]     status_r;
  logic            take;

  // Request sources in priority order; serial port b slots reuse vectors
  always_comb begin
    raw = '0;
    raw[SRC_PWD]   = sleep_request_in | sleep_force;            // see R19
    raw[SRC_LINEC] = cfg_sense_line_c;                           // see R12
    raw[SRC_LVLB]  = level_line_b;                               // see R6
    raw[SRC_LVLA]  = level_line_a;                               // see R6
    raw[SRC_SATX]  = periph_req[0];
    raw[SRC_SARX]  = periph_req[1];
    raw[SRC_EDGE]  = edge_line;
    raw[SRC_BYTE]  = periph_req[2];
    raw[SRC_SBTX]  = lines_from_port_b ? cfg_sense_line_b : 1'b0; // see R13
    raw[SRC_SBRX]  = lines_from_port_b ? cfg_sense_line_a : 1'b0; // see R13
    raw[SRC_TMR]   = periph_req[3];
  end

  // Edge-latched sources: sleep, edge line, and configurable lines per ctrl
  always_comb begin
    latch_en = '0;
    latch_en[SRC_PWD]   = 1'b1;                                  // see R19
    latch_en[SRC_EDGE]  = 1'b1;                                  // see R7
    latch_en[SRC_LINEC] = ctrl_r[2];                             // see R5
    latch_en[SRC_SBTX]  = ctrl_r[1];                             // see R5
    latch_en[SRC_SBRX]  = ctrl_r[0];                             // see R5
    rise = raw & ~raw_q_r;
  end

  // Pending: latched edges sticky, set beats clear; levels follow pin
  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      if (latch_en[i]) begin
        pend_nxt[i] = pend_r[i];
        if ((take && sel.source == 4'(i)) || (force_clear_we && clear_bits[i]))
          pend_nxt[i] = 1'b0;                                    // see R23
        if (rise[i] || (force_clear_we && force_bits[i]))
          pend_nxt[i] = 1'b1;                                    // see R8
      end else begin
        pend_nxt[i] = raw[i] | (force_clear_we & force_bits[i]); // see R8
      end
    end
  end

  // Mask gating, sleep bypasses the mask; nested mode allows preemption
  always_comb begin
    gated = pend_r & mask_r;                                     // see R2
    gated[SRC_PWD] = pend_r[SRC_PWD];                            // see R3
    sel = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (gated[i]) begin                                        // see R1
        sel.valid  = 1'b1;
        sel.source = 4'(i);
        sel.vector = (i == 0) ? VEC_PWD : 16'(VEC_BASE + VEC_STEP * 16'(i - 1));
      end
    end
    gsel = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (active_r[i] && sel.valid && sel.source >= 4'(i))
        gsel[i] = 1'b1;
    end
    // Sequential mode blocks while any handler runs; nested only for higher
    take = sel.valid && gen_r && !hold_r && !(|gsel)           // see R10
           && (ctrl_r[CTRL_NEST] || !(|active_r)) && vector_accept; // see R5
  end

  // Mask, control, global enable and post-write hold
  always_comb begin
    mask_nxt = source_gate_we ? source_gate_wdata : mask_r;
    hold_nxt = source_gate_we;                                   // see R4
    ctrl_nxt = ctrl_we ? ctrl_wdata : ctrl_r;
    gen_nxt  = gen_r;
    if (global_service_off)
      gen_nxt = 1'b0;                                            // see R10
    if (global_service_on)
      gen_nxt = 1'b1;
    active_nxt = active_r;
    for (int i = 0; i < NSRC; i++) begin
      if (active_r[i] && handler_return && !(|(active_r & ((11'h1 << i) - 11'h1))))
        active_nxt[i] = 1'b0;
    end
    if (take)
      active_nxt[sel.source] = 1'b1;
  end

  // Status stack pointer; push on entry, pop on return
  always_comb begin
    sp_nxt = sp_r;
    if (take && sp_r != STK_FULL)
      sp_nxt = sp_r + 4'h1;                                      // see R9
    else if (handler_return && sp_r != 4'h0)
      sp_nxt = sp_r - 4'h1;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mask_r   <= MASK_RST;
      ctrl_r   <= CTRL_RST;
      gen_r    <= 1'b1;                                          // see R11
      hold_r   <= 1'b0;
      pend_r   <= '0;
      raw_q_r  <= '0;
      active_r <= '0;
      sp_r     <= 4'h0;
      vec_r    <= '0;
      status_r <= 16'h0000;
    end else begin
      mask_r   <= mask_nxt;
      ctrl_r   <= ctrl_nxt;
      gen_r    <= gen_nxt;
      hold_r   <= hold_nxt;
      pend_r   <= pend_nxt;
      raw_q_r  <= raw;
      active_r <= active_nxt;
      sp_r     <= sp_nxt;
      vec_r    <= sel;
      vec_r.valid <= sel.valid && gen_r && !hold_r;
      if (handler_return && sp_r != 4'h0)
        status_r <= stk_r[sp_r - 4'h1];                          // see R9
    end
  end

  // Stack memory has no reset; only entries below the pointer are valid
  always_ff @(posedge sys_clk) begin
    if (take && sp_r != STK_FULL)
      stk_r[sp_r] <= status_in;
  end

  // ----------------------------------------------------------------
  // Idle, slow idle and sleep
  // ----------------------------------------------------------------
  dic_pwr_t    ps_r, ps_nxt;
  logic        idle_r, idle_nxt;
  logic [7:0]  div_r, div_nxt, dcnt_r, dcnt_nxt;
  logic [12:0] rec_r, rec_nxt;
  logic        wake_r, wake_nxt;

  // Idle ends on a gated request, at the next slow tick; DMA untouched
  always_comb begin
    idle_nxt = idle_r;                                           // Core only, ports run on, see R15
    div_nxt  = div_r;
    wake_nxt = wake_r;
    dcnt_nxt = (idle_r && div_r != 8'h00) ? dcnt_r + 8'h01 : 8'h00; // see R16
    if (dcnt_nxt == div_r)
      dcnt_nxt = 8'h00;
    if (idle_cmd && !idle_r) begin
      idle_nxt = 1'b1;
      div_nxt  = (idle_div_sel == 3'h0) ? 8'h00 : 8'(DIV_16 << (idle_div_sel - 3'h1));
      wake_nxt = 1'b0;
    end else if (idle_r && (|gated)) begin
      wake_nxt = 1'b1;                                           // see R14
    end
    if (wake_r && (div_r == 8'h00 || dcnt_r == div_r - 8'h01)) begin
      idle_nxt = 1'b0;                                           // see R17
      wake_nxt = 1'b0;
    end
  end

  // Sleep: enter on taken sleep vector, wake once pin and force are both low, count recovery
  always_comb begin
    ps_nxt  = ps_r;
    rec_nxt = rec_r;
    case (ps_r)
      PS_RUN: begin
        if (take && sel.source == SRC_PWD)
          ps_nxt = PS_SLEEP;
      end
      PS_SLEEP: begin
        rec_nxt = osc_stopped ? 13'(STOP_REC) : RUN_REC_CNT;     // see R20
        if (!sleep_request_in && !sleep_force)
          ps_nxt = PS_WAKE;
      end
      PS_WAKE: begin
        rec_nxt = rec_r - 13'h1;
        if (rec_r == 13'h1)
          ps_nxt = PS_RUN;
      end
      default: ps_nxt = PS_RUN;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin                                               // see R21
      ps_r   <= PS_RUN;
      rec_r  <= 13'h0;
      idle_r <= 1'b0;
      div_r  <= 8'h00;
      dcnt_r <= 8'h00;
      wake_r <= 1'b0;
      sleep_ack_out <= 1'b0;
      core_resume   <= 1'b0;
    end else begin
      ps_r   <= ps_nxt;
      rec_r  <= rec_nxt;
      idle_r <= idle_nxt;
      div_r  <= div_nxt;
      dcnt_r <= dcnt_nxt;
      wake_r <= wake_nxt;
      sleep_ack_out <= (ps_nxt == PS_SLEEP);                     // see R22
      core_resume   <= (ps_r == PS_WAKE) && (rec_r == 13'h1);
    end
  end

  // Outputs; context clear picks restart over continue after sleep
  assign context_clear  = core_resume & powerup_context_reset_sel; // see R21
  assign vec_out        = vec_r;
  assign status_out     = status_r;
  assign stack_overflow = take && (sp_r == STK_FULL);
  assign idle_active    = idle_r;
  assign slow_tick      = idle_r && div_r != 8'h00 && dcnt_r == 8'h00; // see R16
  assign pending_out    = pend_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_hold_after_mask: assert property (@(posedge sys_clk) disable iff (rst) // see R4
    source_gate_we |=> !take) else $error("interrupt taken right after mask write");
  chk_mask_gates_src: assert property (@(posedge sys_clk) disable iff (rst) // see R2
    take && sel.source != SRC_PWD |-> mask_r[sel.source]) else $error("masked source taken");
  chk_global_off: assert property (@(posedge sys_clk) disable iff (rst) // see R10
    !gen_r |-> !take) else $error("taken while globally disabled");
  chk_edge_sticky: assert property (@(posedge sys_clk) disable iff (rst) // see R23
    pend_r[SRC_EDGE] && !take && !(force_clear_we && clear_bits[SRC_EDGE]) |=> pend_r[SRC_EDGE])
    else $error("edge request lost");
  chk_sleep_ack: assert property (@(posedge sys_clk) disable iff (rst) // see R22
    $rose(sleep_ack_out) |-> $past(take && sel.source == SRC_PWD))
    else $error("ack without sleep entry");
  // Wake holds 100 cycles; the resume pulse is registered one edge later
  chk_wake_recovery: assert property (@(posedge sys_clk) disable iff (rst) // see R20
    ps_r == PS_SLEEP && ps_nxt == PS_WAKE && !osc_stopped |-> ##101 core_resume)
    else $error("recovery not 100 cycles");
  chk_stack_bound: assert property (@(posedge sys_clk) disable iff (rst) // see R9
    sp_r <= STK_FULL) else $error("stack pointer past depth");
  chk_slow_wake: assert property (@(posedge sys_clk) disable iff (rst) // see R17
    $rose(wake_r) |-> ##[1:129] !idle_r) else $error("slow idle wake too late");
  chk_reset_on: assert property (@(posedge sys_clk) // see R11
    $fell(rst) |-> gen_r) else $error("service off after reset");

  cov_take: cover property (@(posedge sys_clk) disable iff (rst) take);
  cov_sleep: cover property (@(posedge sys_clk) disable iff (rst) ps_r == PS_WAKE);
  cov_slow: cover property (@(posedge sys_clk) disable iff (rst) slow_tick);
  cov_nest: cover property (@(posedge sys_clk) disable iff (rst) take && (|active_r));

endmodule : dic_ctrl

//--- core/dic_pkg.sv
package dic_pkg;

  // ----------------------------------------------------------------
  // Sources, in priority order (index 0 highest after reset)
  // ----------------------------------------------------------------
  localparam int NSRC = 11;
  localparam logic [3:0] SRC_PWD   = 4'h0;
  localparam logic [3:0] SRC_LINEC = 4'h1;
  localparam logic [3:0] SRC_LVLB  = 4'h2;
  localparam logic [3:0] SRC_LVLA  = 4'h3;
  localparam logic [3:0] SRC_SATX  = 4'h4;
  localparam logic [3:0] SRC_SARX  = 4'h5;
  localparam logic [3:0] SRC_EDGE  = 4'h6;
  localparam logic [3:0] SRC_BYTE  = 4'h7;
  localparam logic [3:0] SRC_SBTX  = 4'h8;
  localparam logic [3:0] SRC_SBRX  = 4'h9;
  localparam logic [3:0] SRC_TMR   = 4'hA;

  // ----------------------------------------------------------------
  // Vector addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_PWD   = 16'h002C;
  localparam logic [15:0] VEC_BASE  = 16'h0004;
  localparam logic [15:0] VEC_STEP  = 16'h0004;

  // Mask and control reset values
  localparam logic [NSRC-1:0] MASK_RST = '0;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam int CTRL_NEST = 3;

  // Status stack
  localparam int STK_DEPTH = 12;
  localparam logic [3:0] STK_FULL = 4'hC;

  // Power-down recovery timing, in input clock cycles
  localparam int RUN_REC_CYC  = 100;
  localparam int STOP_REC_CYC = 4096;
  localparam logic [12:0] RUN_REC_CNT = 13'(RUN_REC_CYC);

  // Slow idle divisor codes: 0 none, 1..4 = 16,32,64,128
  localparam logic [7:0] DIV_16 = 8'h10;

  typedef struct packed {
    logic            valid;
    logic [15:0]     vector;
    logic [3:0]      source;
  } dic_vec_t;

  typedef enum {PS_RUN, PS_SLEEP, PS_WAKE} dic_pwr_t;

endpackage : dic_pkg

//--- testbench/dic_src_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Request sources and sleep pin facing the controller
// ----------------------------------------------------------------
module dic_src_model
  import dic_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            rst,
  input  wire logic [NSRC-1:0] req_set,
  input  wire logic            set_go,
  input  wire logic            sleep_on,
  input  wire dic_vec_t        vec_out,
  input  wire logic            vector_accept,
  output logic [NSRC-1:0]      hold_r,
  output logic                 edge_pulse_r,
  output logic                 sleep_pin_r
);
  logic [NSRC-1:0] hold_nxt;

  // Levels stay up until serviced; nothing new is raised meanwhile,
  // so a slowed core always keeps pace
  always_comb begin
    hold_nxt = hold_r;
    if (vec_out.valid && vector_accept) hold_nxt[vec_out.source] = 1'b0;
    if (set_go) hold_nxt = hold_nxt | req_set;
  end

  // Pins change only just after the clock edge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hold_r       <= '0;
      edge_pulse_r <= 1'b0;
      sleep_pin_r  <= 1'b0;
    end else begin
      hold_r       <= hold_nxt;
      edge_pulse_r <= set_go & req_set[6];
      sleep_pin_r  <= sleep_on;
    end
  end
endmodule : dic_src_model

//--- testbench/dsp_interrupt_and_idle_control_tb_top.sv
`timescale 1ns/10ps
module dsp_interrupt_and_idle_control_tb_top;
  import dic_pkg::*;
  localparam int STOP_SIM = 20;
  logic sys_clk = 1'b0, rst = 1'b1, set_go = 1'b0, sleep_on = 1'b0, osc_stopped = 1'b0;
  logic sleep_force = 1'b0, powerup_context_reset_sel = 1'b0, source_gate_we = 1'b0;
  logic ctrl_we = 1'b0, force_clear_we = 1'b0, global_service_on = 1'b0, idle_cmd = 1'b0;
  logic global_service_off = 1'b0, vector_accept = 1'b0, handler_return = 1'b0;
  logic [NSRC-1:0] req_set = '0, source_gate_wdata = '0, force_bits = '0, clear_bits = '0;
  logic [3:0]  ctrl_wdata   = 4'h0;
  logic [2:0]  idle_div_sel = 3'h0;
  logic [15:0] status_in    = 16'h0000;
  logic [15:0] status_out;
  logic [NSRC-1:0] hold, pending_out, r, m;
  logic [31:0] w, seed = 32'd78043;
  logic edge_pulse, sleep_pin, idle_active, slow_tick, sleep_ack_out, context_clear, core_resume;
  logic port_b_lines = 1'b1, stk_ovf;
  dic_vec_t vec_out;
  int failures = 0, compares = 0, n, e;

  always #5 sys_clk = ~sys_clk;

  dic_src_model u_src (.sys_clk(sys_clk), .rst(rst), .req_set(req_set), .set_go(set_go),
    .sleep_on(sleep_on), .vec_out(vec_out), .vector_accept(vector_accept),
    .hold_r(hold), .edge_pulse_r(edge_pulse), .sleep_pin_r(sleep_pin));

  dic_ctrl #(.STOP_REC(STOP_SIM)) u_dut (.sys_clk(sys_clk), .rst(rst),
    .cfg_sense_line_c(hold[1]), .level_line_b(hold[2]), .level_line_a(hold[3]),
    .edge_line(edge_pulse), .cfg_sense_line_b(hold[8]), .cfg_sense_line_a(hold[9]),
    .lines_from_port_b(port_b_lines), .periph_req({hold[10], hold[7], hold[5], hold[4]}),
    .sleep_request_in(sleep_pin), .sleep_force(sleep_force), .osc_stopped(osc_stopped),
    .powerup_context_reset_sel(powerup_context_reset_sel),
    .source_gate_wdata(source_gate_wdata), .source_gate_we(source_gate_we),
    .ctrl_wdata(ctrl_wdata), .ctrl_we(ctrl_we), .force_bits(force_bits),
    .clear_bits(clear_bits), .force_clear_we(force_clear_we),
    .global_service_on(global_service_on), .global_service_off(global_service_off),
    .vector_accept(vector_accept), .handler_return(handler_return), .status_in(status_in),
    .idle_cmd(idle_cmd), .idle_div_sel(idle_div_sel), .status_out(status_out),
    .stack_overflow(stk_ovf), .vec_out(vec_out), .idle_active(idle_active),
    .slow_tick(slow_tick), .sleep_ack_out(sleep_ack_out), .context_clear(context_clear),
    .core_resume(core_resume), .pending_out(pending_out));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // Sleep sits at the top of the table, the rest step by four
  function automatic logic [15:0] exp_vec(int i);
    return (i == 0) ? 16'h002C : 16'(4 * i);
  endfunction : exp_vec

  function automatic int first_set(logic [NSRC-1:0] v);
    for (int i = 0; i < NSRC; i++) if (v[i]) return i;
    return -1;
  endfunction : first_set

  task automatic cyc(int k);
    repeat (k) @(negedge sys_clk);
  endtask : cyc

  task automatic chk(logic ok, string msg);
    compares++;
    if (ok !== 1'b1) begin
      failures++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk

  // One strobe per call, held for exactly one sampling edge
  task automatic op(int k, logic [NSRC-1:0] v);
    @(negedge sys_clk);
    case (k)
      0: {source_gate_we, source_gate_wdata} = {1'b1, v};
      1: {ctrl_we, ctrl_wdata} = {1'b1, v[3:0]};
      2: {force_clear_we, force_bits} = {1'b1, v};
      3: {force_clear_we, clear_bits} = {1'b1, v};
      4: {set_go, req_set} = {1'b1, v};
      5: vector_accept = 1'b1;
      6: handler_return = 1'b1;
      7: global_service_off = 1'b1;
      8: global_service_on = 1'b1;
      default: {idle_cmd, idle_div_sel} = {1'b1, v[2:0]};
    endcase
    @(negedge sys_clk);
    {source_gate_we, ctrl_we, force_clear_we, set_go, handler_return} = '0;
    {global_service_off, global_service_on, idle_cmd} = '0;
    force_bits = '0;
    clear_bits = '0;
    if (k == 5) vector_accept = 1'b0;
  endtask : op

  // Serve every expected request, highest priority first
  task automatic drain(logic [NSRC-1:0] v);
    int k;
    while (v != '0) begin
      cyc(4);
      k = first_set(v);
      chk(vec_out.valid === 1'b1 && vec_out.vector === exp_vec(k), "wrong vector");
      op(5, '0);
      op(6, '0);
      v[k] = 1'b0;
    end
    cyc(4);
    chk(vec_out.valid === 1'b0, "masked source served");
  endtask : drain

  task automatic give_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(6);
    rst = 1'b0;
    cyc(1);
    chk(pending_out === '0 && vec_out.valid === 1'b0 && sleep_ack_out === 1'b0,
      "reset");
    op(0, '1);
    op(4, 11'h040);
    cyc(4);
    op(5, '0);
    cyc(1);
    chk(pending_out[6] === 1'b0, "not served after reset");
    op(6, '0);
    // Global off holds a latched edge; software clear and force act on it
    op(7, '0);
    op(4, 11'h040);
    cyc(4);
    op(5, '0);
    cyc(1);
    chk(pending_out[6] === 1'b1, "served while off");
    op(3, 11'h040);
    cyc(1);
    chk(pending_out[6] === 1'b0, "clear ignored");
    op(2, 11'h040);
    cyc(1);
    chk(pending_out[6] === 1'b1, "force ignored");
    op(8, '0);
    cyc(3);
    op(5, '0);
    cyc(1);
    chk(pending_out[6] === 1'b0, "not served after on");
    op(6, '0);
    // Edge setting on line c lets a clear stick; level line a ignores it
    op(0, '0);
    op(1, 11'h004);
    op(4, 11'h00A);
    cyc(3);
    op(3, 11'h00A);
    cyc(1);
    chk(pending_out[3:1] === 3'b100, "sense mode");
    op(1, '0);
    cyc(2);
    chk(pending_out[1] === 1'b1, "line c not level");
    op(0, '1);
    drain(11'h00A);
    // Port b as a serial port raises no line requests
    port_b_lines = 1'b0;
    op(4, 11'h300);
    cyc(2);
    chk(pending_out[9:8] === 2'b00, "port b lines while serial");
    port_b_lines = 1'b1;
    drain(11'h300);
    // Random request sets under random masks and sense modes, then unmasked
    for (int it = 0; it < 20; it++) begin
      w = xs();
      r = {w[10:1], 1'b0};
      w = xs();
      m = w[10:0];
      op(1, {8'h00, w[13:11]});
      op(0, m);
      op(4, r);
      drain(r & m);
      op(0, '1);
      drain(r & ~m);
    end
    // Sequential refuses, nested preempts, status stack unwinds
    w = xs();
    op(1, '0);
    op(4, 11'h400);
    cyc(4);
    op(5, '0);
    op(4, 11'h040);
    cyc(4);
    op(5, '0);
    cyc(1);
    chk(pending_out[6] === 1'b1, "sequential preempted");
    op(6, '0);
    cyc(3);
    op(5, '0);
    op(6, '0);
    op(1, 11'h008);
    status_in = w[15:0];
    op(4, 11'h400);
    cyc(4);
    op(5, '0);
    status_in = ~w[15:0];
    op(4, 11'h040);
    cyc(4);
    op(5, '0);
    cyc(1);
    chk(pending_out[6] === 1'b0, "nested not preempted");
    op(6, '0);
    chk(status_out === ~w[15:0], "stack top");
    op(6, '0);
    chk(status_out === w[15:0], "stack bottom");
    // Accept held high across a mask write: one cycle of hold-off first
    op(0, '0);
    op(4, 11'h040);
    cyc(3);
    vector_accept = 1'b1;
    op(0, '1);
    cyc(1);
    chk(pending_out[6] === 1'b1, "taken right after mask write");
    chk(stk_ovf === 1'b0, "stack overflow flagged");
    cyc(1);
    chk(pending_out[6] === 1'b0, "not taken after hold");
    vector_accept = 1'b0;
    op(6, '0);
    // Idle and every slow-idle divisor
    for (int s = 0; s < 5; s++) begin
      op(9, NSRC'(s));
      cyc(1);
      chk(idle_active === 1'b1, "not idle");
      if (s > 0) begin
        n = 0;
        while (slow_tick !== 1'b1 && n < 300) begin
          cyc(1);
          n++;
        end
        n = 0;
        do begin
          cyc(1);
          n++;
        end while (slow_tick !== 1'b1 && n < 300);
        chk(n == (8 << s), "tick period");
      end
      op(4, 11'h400);
      vector_accept = 1'b1;
      n = 0;
      while (idle_active === 1'b1 && n < 300) begin
        cyc(1);
        n++;
      end
      vector_accept = 1'b0;
      chk(n <= (8 << s) + 4, "slow wake");
      op(6, '0);
    end
    // Sleep by pin, then by force, with both recovery lengths
    op(0, '0);
    for (int k = 0; k < 2; k++) begin
      osc_stopped = k[0];
      powerup_context_reset_sel = k[0];
      sleep_force = k[0];
      sleep_on = !k[0];
      cyc(4);
      chk(vec_out.valid === 1'b1 && vec_out.vector === exp_vec(0), "sleep vector");
      op(5, '0);
      cyc(2);
      chk(sleep_ack_out === 1'b1, "no sleep ack");
      sleep_force = 1'b0;
      sleep_on = 1'b0;
      e = k ? STOP_SIM : RUN_REC_CYC;
      n = 0;
      while (core_resume !== 1'b1 && n < 5000) begin
        cyc(1);
        n++;
      end
      chk(n >= e && n <= e + 4, "recovery length");
      chk(context_clear === k[0], "context select");
      op(6, '0);
    end
    sleep_on = 1'b1;
    cyc(4);
    op(5, '0);
    cyc(2);
    rst = 1'b1;
    sleep_on = 1'b0;
    cyc(2);
    rst = 1'b0;
    cyc(1);
    chk(sleep_ack_out === 1'b0, "reset kept sleep");
    give_verdict();
  end

  // Whole run is a few thousand cycles; far beyond that means a hang
  initial begin
    #500us;
    failures++;
    give_verdict();
  end
endmodule : dsp_interrupt_and_idle_control_tb_top
